/* File: hdl/pwdt_pkg.sv */
// Shared constants for the PWM output, dead-time and event trigger stage
package pwdt_pkg;
  // Sizes
  localparam int NUM_GEN = 4;
  localparam int TB_W = 13;
  localparam int DT_W = 12;
  localparam int PS_W = 4;
  // Register byte offsets; generator g sits at GEN_STRIDE * g
  localparam logic [7:0] GEN_STRIDE = 8'h10;
  localparam logic [1:0] FLD_CTRL = 2'h0;
  localparam logic [1:0] FLD_DUTY = 2'h1;
  localparam logic [1:0] FLD_DT = 2'h2;
  localparam logic [1:0] FLD_ALT = 2'h3;
  localparam logic [7:0] OFF_TBCTRL = 8'h40;
  localparam logic [7:0] OFF_EVCMP = 8'h44;
  localparam logic [7:0] OFF_STATUS = 8'h48;
  // Generator control and TBCTRL fields
  localparam int CTRL_INDEP_BIT = 0;
  localparam int CTRL_DTS_LSB = 1;
  localparam int CTRL_W = 3;
  localparam int TBCTRL_PS_LSB = 0;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [DT_W-1:0] DT_RST = 12'h000;
  localparam logic [15:0] EVCMP_RST = 16'h0000;
  localparam logic [PS_W-1:0] PS_RST = 4'h0;
  // Duty limits
  localparam logic [15:0] DUTY_ZERO = 16'h0000;
  localparam logic [15:0] DUTY_MIN = 16'h0008;
  localparam logic [15:0] DUTY_MAX = 16'hFFEF;
  localparam logic [15:0] DUTY_FULL = 16'hFFFF;
  // Dead-time selection
  typedef enum logic [1:0] {
    DTS_POS = 2'b00,
    DTS_NEG = 2'b01,
    DTS_OFF = 2'b10,
    DTS_OFF2 = 2'b11
  } pwdt_dts_type;
endpackage : pwdt_pkg

/* File: hdl/pwdt_dead_time.sv */
// Dead-time unit for one output pair
`timescale 1ns/1ps
`default_nettype none
module pwdt_dead_time (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Compare result and settings
  input wire logic active_i,
  input wire logic indep_i,
  input wire logic [1:0] dts_i,
  input wire logic [pwdt_pkg::DT_W-1:0] dt_main_i,
  input wire logic [pwdt_pkg::DT_W-1:0] dt_alt_i,
  // Pair outputs
  output logic high_o,
  output logic low_o
);
  logic act_q;
  logic rise, fall, neg, on;
  logic tgt_h, tgt_l, ld_h, ld_l;
  logic [pwdt_pkg::DT_W-1:0] cnt_h_q, cnt_h_d, cnt_l_q, cnt_l_d;

  ////////////////////////////////////////////////////////////
  // Edge detect and targets
  assign rise = active_i & ~act_q;
  assign fall = ~active_i & act_q;
  assign neg = (dts_i == pwdt_pkg::DTS_NEG);
  assign on = ~dts_i[1];
  assign tgt_h = active_i;
  assign tgt_l = indep_i ? active_i : ~active_i;
  // Positive delays turn-on, negative delays turn-off
  assign ld_h = neg ? fall : rise;
  assign ld_l = neg ? (indep_i ? fall : rise) : (indep_i ? rise : fall);

  // Reload on a new edge even mid-count; LSB goes to fine adjust
  always_comb begin
    cnt_h_d = cnt_h_q;
    cnt_l_d = cnt_l_q;
    if (ld_h) cnt_h_d = {1'b0, dt_main_i[pwdt_pkg::DT_W-1:1]};
    else if (cnt_h_q != '0) cnt_h_d = cnt_h_q - 1'b1;
    if (ld_l) cnt_l_d = {1'b0, dt_alt_i[pwdt_pkg::DT_W-1:1]};
    else if (cnt_l_q != '0) cnt_l_d = cnt_l_q - 1'b1;
  end

  // Counters and edge history
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      act_q <= 1'b0;
      cnt_h_q <= '0;
      cnt_l_q <= '0;
    end else begin
      act_q <= active_i;
      cnt_h_q <= cnt_h_d;
      cnt_l_q <= cnt_l_d;
    end
  end

  // Registered pins, so glitches never reach the drivers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      high_o <= 1'b0;
      low_o <= 1'b0;
    end else if (!on) begin
      high_o <= tgt_h;
      low_o <= tgt_l;
    end else if (neg) begin
      high_o <= tgt_h | (cnt_h_d != '0);
      low_o <= tgt_l | (cnt_l_d != '0);
    end else begin
      high_o <= tgt_h & (cnt_h_d == '0);
      low_o <= tgt_l & (cnt_l_d == '0);
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  chk_pos_gap: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($rose(high_o) && $past(dts_i) == pwdt_pkg::DTS_POS && !$past(indep_i)) |-> !$past(low_o))
    else $error("high side rose while low side was still on");
  chk_off_follow: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    dts_i[1] |=> high_o == $past(active_i))
    else $error("disabled dead time did not pass the compare through");
  chk_neg_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (fall && neg && dt_main_i[pwdt_pkg::DT_W-1:1] != '0) |=> high_o)
    else $error("negative dead time did not stretch the high side");
endmodule : pwdt_dead_time
`default_nettype wire

/* File: hdl/pwdt_postscale.sv */
// Special event trigger postscaler
`timescale 1ns/1ps
`default_nettype none
module pwdt_postscale (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Events and control
  input wire logic match_i,
  input wire logic clear_i,
  input wire logic [pwdt_pkg::PS_W-1:0] ratio_i,
  // Trigger pulse
  output logic trig_o
);
  logic [pwdt_pkg::PS_W-1:0] cnt_q;
  logic done;

  // At or above, so lowering the ratio mid-count never runs past 16
  assign done = match_i && (cnt_q >= ratio_i);

  // Count matches; clear restarts the sequence
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || clear_i) cnt_q <= '0;
    else if (done) cnt_q <= '0;
    else if (match_i) cnt_q <= cnt_q + 1'b1;
  end

  // One-cycle trigger, no enable gating
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) trig_o <= 1'b0;
    else trig_o <= done;
  end

  chk_ps_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    clear_i |=> cnt_q == '0)
    else $error("postscaler not cleared");
  chk_ps_ratio: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (match_i && ratio_i == '0 && !clear_i) |=> trig_o)
    else $error("1:1 postscale missed a trigger");
endmodule : pwdt_postscale
`default_nettype wire

/* File: hdl/pwdt_output_stage.sv */
// PWM output stage: duty compare, dead time, event trigger, APB registers
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pwdt_output_stage (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,

  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,

  // Time base counts
  input wire logic [pwdt_pkg::TB_W-1:0] primary_timebase_count_i,
  input wire logic [pwdt_pkg::NUM_GEN*pwdt_pkg::TB_W-1:0] gen_count_i,

  // Output pins
  output logic [pwdt_pkg::NUM_GEN-1:0] high_side_output_o,
  output logic [pwdt_pkg::NUM_GEN-1:0] low_side_output_o,

  // Fine-edge adjust hand-off
  output logic [3*pwdt_pkg::NUM_GEN-1:0] duty_fine_o,
  output logic [pwdt_pkg::NUM_GEN-1:0] dt_fine_o,
  output logic [pwdt_pkg::NUM_GEN-1:0] alt_fine_o,

  // Converter trigger
  output logic event_trigger_o
);

  ////////////////////////////////////////////////////////////
  // Declarations

  localparam int NG = pwdt_pkg::NUM_GEN;
  localparam int TBW = pwdt_pkg::TB_W;
  localparam int DTW = pwdt_pkg::DT_W;

  logic [pwdt_pkg::CTRL_W-1:0] generator_control_reg_q [NG];
  logic [15:0] duty_q [NG];
  logic [DTW-1:0] pair_dead_time_value_q [NG];
  logic [DTW-1:0] alternate_dead_time_value_q [NG];
  logic [pwdt_pkg::PS_W-1:0] event_postscale_select_q;
  logic [15:0] event_compare_value_q;

  logic [NG-1:0] active;
  logic [NG-1:0] indep;
  logic [1:0] dts [NG];

  logic setup, access, wr;
  logic hit;
  logic [3:0] gsel;
  logic in_gen;
  logic [1:0] fsel;
  logic [31:0] rd_d;
  logic [31:0] prdata_q;

  logic match, match_q, ev_hit;
  logic ev_wr;

  ////////////////////////////////////////////////////////////
  // APB decode

  // Setup latches read data so prdata comes from a flop
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign in_gen = (paddr_i < pwdt_pkg::OFF_TBCTRL);
  assign gsel = paddr_i[7:4];
  assign fsel = paddr_i[3:2];

  // Word aligned, inside the map
  always_comb begin
    hit = 1'b0;
    if (paddr_i[1:0] == 2'b00) begin
      if (in_gen) hit = 1'b1;
      else if (paddr_i == pwdt_pkg::OFF_TBCTRL) hit = 1'b1;
      else if (paddr_i == pwdt_pkg::OFF_EVCMP) hit = 1'b1;
      else if (paddr_i == pwdt_pkg::OFF_STATUS) hit = 1'b1;
    end
  end

  // No wait states; error only for unmapped words
  assign pready_o = access;
  assign pslverr_o = access & ~hit;
  assign wr = access & pwrite_i & hit;
  assign ev_wr = wr & (paddr_i == pwdt_pkg::OFF_EVCMP);
  assign prdata_o = prdata_q;

  ////////////////////////////////////////////////////////////
  // Read path

  // Unused bits read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (in_gen) begin
      case (fsel)
        pwdt_pkg::FLD_CTRL: rd_d[pwdt_pkg::CTRL_W-1:0] = generator_control_reg_q[gsel[1:0]];
        pwdt_pkg::FLD_DUTY: rd_d[15:0] = duty_q[gsel[1:0]];
        pwdt_pkg::FLD_DT: rd_d[DTW-1:0] = pair_dead_time_value_q[gsel[1:0]];
        pwdt_pkg::FLD_ALT: rd_d[DTW-1:0] = alternate_dead_time_value_q[gsel[1:0]];
        default: rd_d = 32'h0000_0000;
      endcase
    end else if (paddr_i == pwdt_pkg::OFF_TBCTRL) begin
      rd_d[pwdt_pkg::TBCTRL_PS_LSB +: pwdt_pkg::PS_W] = event_postscale_select_q;
    end else if (paddr_i == pwdt_pkg::OFF_EVCMP) begin
      rd_d[15:0] = event_compare_value_q;
    end else if (paddr_i == pwdt_pkg::OFF_STATUS) begin
      // Live pin state for software
      rd_d[2*NG-1:0] = {low_side_output_o, high_side_output_o};
    end
  end

  // Read data flop
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite_i) prdata_q <= rd_d;
  end

  ////////////////////////////////////////////////////////////
  // Generator registers

  // Control: mode bit and dead-time select
  always_ff @(posedge ref_clk_i) begin
    for (int g = 0; g < NG; g++) begin
      if (reset_i) begin
        generator_control_reg_q[g] <= pwdt_pkg::CTRL_RST;
      end else if (wr && in_gen && gsel[1:0] == 2'(g) && fsel == pwdt_pkg::FLD_CTRL) begin
        generator_control_reg_q[g] <= pwdata_i[pwdt_pkg::CTRL_W-1:0];
      end
    end
  end

  // Duty values; range is software's concern, not clamped
  always_ff @(posedge ref_clk_i) begin
    for (int g = 0; g < NG; g++) begin
      if (reset_i) begin
        duty_q[g] <= pwdt_pkg::DUTY_RST;
      end else if (wr && in_gen && gsel[1:0] == 2'(g) && fsel == pwdt_pkg::FLD_DUTY) begin
        duty_q[g] <= pwdata_i[15:0];
      end
    end
  end

  // Primary and alternate dead-time values
  always_ff @(posedge ref_clk_i) begin
    for (int g = 0; g < NG; g++) begin
      if (reset_i) begin
        pair_dead_time_value_q[g] <= pwdt_pkg::DT_RST;
        alternate_dead_time_value_q[g] <= pwdt_pkg::DT_RST;
      end else if (wr && in_gen && gsel[1:0] == 2'(g)) begin
        if (fsel == pwdt_pkg::FLD_DT) begin
          pair_dead_time_value_q[g] <= pwdata_i[DTW-1:0];
        end
        if (fsel == pwdt_pkg::FLD_ALT) begin
          alternate_dead_time_value_q[g] <= pwdata_i[DTW-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Event registers

  // Postscale select and compare value
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      event_postscale_select_q <= pwdt_pkg::PS_RST;
      event_compare_value_q <= pwdt_pkg::EVCMP_RST;
    end else if (wr) begin
      if (paddr_i == pwdt_pkg::OFF_TBCTRL) begin
        event_postscale_select_q <= pwdata_i[pwdt_pkg::TBCTRL_PS_LSB +: pwdt_pkg::PS_W];
      end
      if (paddr_i == pwdt_pkg::OFF_EVCMP) begin
        event_compare_value_q <= pwdata_i[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Duty compare and dead-time units

  genvar gi;
  generate
    for (gi = 0; gi < NG; gi++) begin : g_gen
      logic [TBW-1:0] cnt;
      assign cnt = gen_count_i[gi*TBW +: TBW];
      assign indep[gi] = generator_control_reg_q[gi][pwdt_pkg::CTRL_INDEP_BIT];
      assign dts[gi] = generator_control_reg_q[gi][pwdt_pkg::CTRL_DTS_LSB +: 2];

      // End values pin the output; else compare top 13 bits
      always_comb begin
        if (duty_q[gi] == pwdt_pkg::DUTY_ZERO) active[gi] = 1'b0;
        else if (duty_q[gi] == pwdt_pkg::DUTY_FULL) active[gi] = 1'b1;
        else active[gi] = (cnt <= duty_q[gi][15:3]);
      end

      // Same unit serves both output modes
      pwdt_dead_time u_dt (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .active_i(active[gi]),
        .indep_i(indep[gi]),
        .dts_i(dts[gi]),
        .dt_main_i(pair_dead_time_value_q[gi]),
        .dt_alt_i(alternate_dead_time_value_q[gi]),
        .high_o(high_side_output_o[gi]),
        .low_o(low_side_output_o[gi])
      );

      // Low bits bypass the coarse counters
      assign duty_fine_o[3*gi +: 3] = duty_q[gi][2:0];
      assign dt_fine_o[gi] = pair_dead_time_value_q[gi][0];
      assign alt_fine_o[gi] = alternate_dead_time_value_q[gi][0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////
  // Special event trigger

  // Count may dwell on the match value; take only its first cycle
  assign match = (primary_timebase_count_i == event_compare_value_q[15:3]);
  assign ev_hit = match & ~match_q;

  // Match history
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) match_q <= 1'b0;
    else match_q <= match;
  end

  // Postscaler, cleared by compare writes
  pwdt_postscale u_ps (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .match_i(ev_hit),
    .clear_i(ev_wr),
    .ratio_i(event_postscale_select_q),
    .trig_o(event_trigger_o)
  );

  ////////////////////////////////////////////////////////////
  // Checks

  chk_duty_zero_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($past(duty_q[0]) == pwdt_pkg::DUTY_ZERO && $past(dts[0][1]) && !$past(indep[0]))
      |-> (!high_side_output_o[0] && low_side_output_o[0]))
    else $error("zero duty did not hold the pair inactive");

  chk_indep_same: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    ($past(indep[1]) && $past(dts[1][1])) |-> high_side_output_o[1] == low_side_output_o[1])
    else $error("independent mode pins differ");

  chk_evt_cause: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    event_trigger_o |-> $past(ev_hit))
    else $error("event trigger without a compare match");

endmodule : pwdt_output_stage
`default_nettype wire

/* File: bench/pwdt_fet_model.sv */
// Behavioural model of the gate drivers and power switches on pair 0
`timescale 1ns/1ps
`default_nettype none
module pwdt_fet_model (
  // Clock
  input wire logic ref_clk_i,
  // Gate drives
  input wire logic high_i,
  input wire logic low_i,
  // Cycles with both switches conducting
  output logic [15:0] overlap_o
);
  ////////////////////////////////////////////////////////////////
  // Shoot-through tally; a real bridge would short the rail here
  initial overlap_o = 16'h0000;
  always @(posedge ref_clk_i) begin
    if (high_i === 1'b1 && low_i === 1'b1) begin
      overlap_o <= overlap_o + 16'h0001;
    end
  end
endmodule : pwdt_fet_model
`default_nettype wire

/* File: bench/pwdt_output_stage_bench.sv */
// Self-checking bench for the PWM output, dead-time and event trigger stage
`timescale 1ns/1ps
`default_nettype none
module pwdt_output_stage_bench;
  typedef struct {logic [2:0] ctrl; logic [15:0] duty; logic [12:0] cnt; logic h; logic l;} pwdt_duty_row_type;
  typedef struct {logic [2:0] ctrl; int rh; int rl; int fh; int fl; logic ov;} pwdt_dt_row_type;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic trig;
  logic [12:0] cnt = 13'h1000;
  logic [12:0] pcnt = 13'h1FFF;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] dtf;
  logic [3:0] atf;
  logic [11:0] dyf;
  logic [15:0] ovl;
  logic [15:0] ov;
  int failures = 0;
  int checks_done = 0;
  int trig_n = 0;
  int g;
  int th;
  int tl;
  int ps [3] = '{0, 1, 15};
  // Duty compare cases: the zero and full end values and in-range duties
  pwdt_duty_row_type drow [8] = '{
    '{3'h4, 16'h0000, 13'h0000, 1'b0, 1'b1},
    '{3'h4, 16'hFFFF, 13'h1FFF, 1'b1, 1'b0},
    '{3'h4, 16'h0008, 13'h0000, 1'b1, 1'b0},
    '{3'h4, 16'h0008, 13'h0002, 1'b0, 1'b1},
    '{3'h5, 16'h0108, 13'h0021, 1'b1, 1'b1},
    '{3'h5, 16'h0108, 13'h0022, 1'b0, 1'b0},
    '{3'h4, 16'hFFEF, 13'h1FFD, 1'b1, 1'b0},
    '{3'h4, 16'hFFEF, 13'h1FFE, 1'b0, 1'b1}};
  // Edge delays with primary 2 and alternate 3 cycles
  pwdt_dt_row_type trow [4] = '{
    '{3'h0, 4, 2, 2, 5, 1'b0},
    '{3'h2, 2, 5, 4, 2, 1'b1},
    '{3'h1, 4, 5, 2, 2, 1'b1},
    '{3'h6, 2, 2, 2, 2, 1'b0}};

  ////////////////////////////////////////////////////////////////
  // Clock, design and far-side model
  always #25 clk = ~clk;
  pwdt_output_stage dut_u (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .primary_timebase_count_i(pcnt), .gen_count_i({4{cnt}}), .high_side_output_o(hi),
    .low_side_output_o(lo), .duty_fine_o(dyf), .dt_fine_o(dtf), .alt_fine_o(atf), .event_trigger_o(trig));
  pwdt_fet_model fet_u (.ref_clk_i(clk), .high_i(hi[0]), .low_i(lo[0]), .overlap_o(ovl));
  // Trigger pulses seen, one per high cycle
  always @(posedge clk) if (trig === 1'b1) trig_n++;

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 16);
    chk(prdy, 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk(e, experr);
  endtask : rd

  // Edges until each pin of pair 0 changes; 15 means no change
  task automatic meas(output int mh, output int ml);
    logic h0;
    logic l0;
    h0 = hi[0];
    l0 = lo[0];
    mh = 15;
    ml = 15;
    for (int k = 1; k < 15; k++) begin
      @(negedge clk);
      if (mh == 15 && hi[0] !== h0) mh = k;
      if (ml == 15 && lo[0] !== l0) ml = k;
    end
  endtask : meas

  task automatic step(input logic [12:0] v, output int mh, output int ml);
    @(posedge clk);
    cnt <= v;
    meas(mh, ml);
  endtask : step

  // Primary count visits the compare value n times
  task automatic hits(input logic [12:0] v, input int n);
    repeat (n) begin
      @(posedge clk);
      pcnt <= v;
      @(posedge clk);
      pcnt <= 13'h1FFF;
    end
    repeat (3) @(posedge clk);
  endtask : hits

  task automatic stop_test();
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////
  // Watchdog; the whole run needs fewer than a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk({hi, lo, trig}, 9'h000);
    rd(8'h00, 32'h0, 1'b0);
    rd(8'h44, 32'h0, 1'b0);
    // Table of duty compare cases, spread over the generators
    foreach (drow[i]) begin
      g = i % 4;
      wr(8'(g * 16), {29'h0, drow[i].ctrl});
      wr(8'(g * 16 + 4), {16'h0, drow[i].duty});
      @(posedge clk);
      cnt <= drow[i].cnt;
      repeat (3) @(negedge clk);
      chk({hi[g], lo[g]}, {drow[i].h, drow[i].l});
    end
    // Dead-time modes on pair 0
    wr(8'h04, 32'h0000_0100);
    wr(8'h08, 32'h0000_0004);
    wr(8'h0C, 32'h0000_0006);
    foreach (trow[i]) begin
      wr(8'h00, {29'h0, trow[i].ctrl});
      step(13'h1000, th, tl);
      ov = ovl;
      step(13'h0000, th, tl);
      chk(th, trow[i].rh);
      chk(tl, trow[i].rl);
      step(13'h1000, th, tl);
      chk(th, trow[i].fh);
      chk(tl, trow[i].fl);
      chk(ovl != ov, trow[i].ov);
    end
    // Short glitch of the compare output restarts the delay
    wr(8'h00, 32'h0);
    step(13'h1000, th, tl);
    @(posedge clk);
    cnt <= 13'h0000;
    @(posedge clk);
    cnt <= 13'h1000;
    @(posedge clk);
    cnt <= 13'h0000;
    meas(th, tl);
    chk(th, 4);
    // Low bits handed to the fine-edge logic
    wr(8'h14, 32'h0000_0103);
    wr(8'h18, 32'h0000_0005);
    wr(8'h1C, 32'h0000_000A);
    @(negedge clk);
    chk({dyf[5:3], dtf[1], atf[1]}, 5'b01110);
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28, 32'h0000_0FFF, 1'b0);
    rd(8'h4C, 32'h0, 1'b1);
    // Postscale ratios
    foreach (ps[i]) begin
      wr(8'h40, ps[i]);
      wr(8'h44, 32'h0000_0050);
      trig_n = 0;
      hits(13'h00A, 16);
      chk(trig_n, 16 / (ps[i] + 1));
    end
    // Compare write in mid-count clears the postscaler
    wr(8'h40, 32'h2);
    wr(8'h44, 32'h0000_0050);
    trig_n = 0;
    hits(13'h00A, 2);
    wr(8'h44, 32'h0000_0050);
    hits(13'h00A, 2);
    chk(trig_n, 0);
    hits(13'h00A, 1);
    chk(trig_n, 1);
    // Reset in mid-count clears it too
    wr(8'h44, 32'h0);
    trig_n = 0;
    hits(13'h000, 2);
    @(posedge clk);
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h40, 32'h0, 1'b0);
    wr(8'h40, 32'h2);
    hits(13'h000, 2);
    chk(trig_n, 0);
    hits(13'h000, 1);
    chk(trig_n, 1);
    stop_test();
  end
endmodule : pwdt_output_stage_bench
`default_nettype wire
